// ===== src/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  // -------------------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // -------------------------------------------------------------------------
  localparam logic [7:0] IDX_MAIN    = 8'h00;
  localparam logic [7:0] IDX_ACCUM   = 8'h01;
  localparam logic [7:0] IDX_REFCLK  = 8'h02;
  localparam logic [7:0] IDX_TIMING  = 8'h03;
  localparam logic [7:0] IDX_WINDOW  = 8'h04;
  localparam logic [7:0] IDX_COMMAND = 8'h08;
  localparam logic [7:0] IDX_FLAGS   = 8'h0B;
  localparam logic [7:0] IDX_RESULT  = 8'h10;

  // -------------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------------
  localparam logic [7:0] RST_MAIN   = 8'h00;
  localparam logic [7:0] RST_ACCUM  = 8'h00;
  localparam logic [7:0] RST_REFCLK = 8'h00;
  localparam logic [7:0] RST_TIMING = 8'h00;
  localparam logic [7:0] RST_WINDOW = 8'h00;

  // -------------------------------------------------------------------------
  // writable bit masks and field positions
  // -------------------------------------------------------------------------
  localparam logic [7:0] MASK_MAIN   = 8'h87;
  localparam logic [7:0] MASK_ACCUM  = 8'h07;
  localparam logic [7:0] MASK_REFCLK = 8'h77;
  localparam logic [7:0] MASK_TIMING = 8'hFF;
  localparam logic [7:0] MASK_WINDOW = 8'h07;
  localparam int BIT_ENABLE   = 0;
  localparam int BIT_CONTINUOUS_CONVERSION  = 1;
  localparam int BIT_RES8     = 2;
  localparam int BIT_STBYRUN  = 7;
  localparam int BIT_SAMPLE_CAP_SELECT  = 6;
  localparam int POS_REF      = 4;
  localparam int POS_DIV      = 0;
  localparam int POS_STARTUP  = 5;
  localparam int BIT_VARIATE  = 4;
  localparam int POS_SDELAY   = 0;
  localparam int BIT_START    = 0;
  localparam int BIT_RESULT_READY_FLAG   = 0;
  localparam int BIT_WINFLAG  = 1;

  // -------------------------------------------------------------------------
  // field codes and timing
  // -------------------------------------------------------------------------
  localparam logic [2:0] ACC_RESERVED  = 3'h7;
  localparam logic [1:0] REF_INTERNAL  = 2'h0;
  localparam logic [1:0] REF_RESERVED  = 2'h3;
  localparam logic [2:0] WIN_MAX       = 3'h4;
  localparam logic [2:0] STARTUP_MAX   = 3'h5;
  localparam int         STARTUP_BASE  = 16;
  localparam int         CONV_CYCLES   = 13;
  localparam logic [1:0] AXI_OKAY      = 2'b00;
  localparam logic [1:0] AXI_SLVERR    = 2'b10;

  typedef enum logic [2:0] {
    ST_IDLE, ST_STARTUP, ST_CONVERT, ST_GAP, ST_DONE
  } seq_state_t;

endpackage

// ===== src/adc_conversion_control.sv
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
// How it works
// - bit 7 of main control keeps the converter running in standby.
// - resolution_select 0 keeps all ten result bits.
// - resolution_select 1 drops the two lowest bits before use.
// - continuous mode starts on conversion_start, then restarts after each completion.
// - each continuous completion sets result_ready_flag.
// - bit 0 of main control enables the converter.
// - accumulation_count 0 none, 1..6 give 2..64 samples, 7 reserved.
// - accumulated samples sum into result as one conversion.
// - bit 6 of third register selects reduced sampling capacitance.
// - reference_select 0 internal, 1 supply, 2 external pin, 3 reserved.
// - converter clock is peripheral clock divided by 2 shl code.
// - enable, or a switch to internal reference with the sequencer idle, waits startup_delay converter clocks.
// - wake from deep sleep with the sequencer idle also waits startup_delay.
// - delay variation increments sample_delay after each sample, wrapping.
// - sample_delay converter clocks pass between consecutive samples.
// - sampling capacitor stays open during the inter-sample delay.
// - window_compare_mode 0..4 decode; other codes reserved.
// - writing conversion_start begins; reads 1 while busy, self-clears on completion unless continuous mode is set.
// - result_ready_flag sets when a new result is stored.
module adc_conversion_control
  import adc_ctrl_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  // axi4-lite write response
  output      logic [1:0]        s_axi_bresp,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  output      logic [31:0]       s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // system power state
  input  wire logic              standby_sleep,
  input  wire logic              deep_sleep_wake,
  // analog front end
  input  wire logic [9:0]        sample_value,
  output      logic              converter_clock,
  output      logic              sample_cap_closed,
  output      logic              sample_cap_reduced,
  output      logic [1:0]        reference_sel_out,
  output      logic [2:0]        window_mode_out,
  output      logic              result_ready_event
);

  // -------------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------------
  logic [7:0]  main_q, accum_q, refclk_q, timing_q, window_q;
  logic        start_q, result_ready_flag_q;
  logic [15:0] result_q, acc_sum_q;
  logic [7:0]  div_cnt_q;
  logic        cclk_q, ctick_q;
  logic [8:0]  wait_q;
  logic [6:0]  samples_q;
  seq_state_t  state_q;
  logic        enable_prev_q, refint_prev_q;

  logic        wr_fire, rd_fire, aw_hold_q, w_hold_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_go;
  logic [7:0]  wr_idx, rd_idx, wr_byte;
  logic        done_pulse, running, startup_trig, sample_end;
  logic [6:0]  samples_total;
  logic [8:0]  startup_cycles;
  logic [9:0]  trimmed;

  // -------------------------------------------------------------------------
  // axi4-lite slave
  // -------------------------------------------------------------------------
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign wr_go         = aw_hold_q && w_hold_q;
  assign wr_idx        = 8'(aw_addr_q >> 2);
  assign rd_idx        = 8'(s_axi_araddr >> 2);
  assign wr_byte       = w_strb_q[0] ? w_data_q[7:0] : 8'h00;
  assign wr_fire       = wr_go && w_strb_q[0];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  function automatic logic mapped(input logic [7:0] idx);
    mapped = (idx == IDX_MAIN) || (idx == IDX_ACCUM) || (idx == IDX_REFCLK) ||
             (idx == IDX_TIMING) || (idx == IDX_WINDOW) || (idx == IDX_COMMAND) ||
             (idx == IDX_FLAGS) || (idx == IDX_RESULT);
  endfunction

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(wr_idx) ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= AXI_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(rd_idx) ? AXI_OKAY : AXI_SLVERR;
      case (rd_idx)
        IDX_MAIN:    s_axi_rdata <= {24'h0, main_q};
        IDX_ACCUM:   s_axi_rdata <= {24'h0, accum_q};
        IDX_REFCLK:  s_axi_rdata <= {24'h0, refclk_q};
        IDX_TIMING:  s_axi_rdata <= {24'h0, timing_q};
        IDX_WINDOW:  s_axi_rdata <= {24'h0, window_q};
        IDX_COMMAND: s_axi_rdata <= {31'h0, start_q};
        IDX_FLAGS:   s_axi_rdata <= {31'h0, result_ready_flag_q};
        IDX_RESULT:  s_axi_rdata <= {16'h0, result_q};
        default:     s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // control registers
  // -------------------------------------------------------------------------
  // masked writes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      main_q   <= RST_MAIN;
      accum_q  <= RST_ACCUM;
      refclk_q <= RST_REFCLK;
      window_q <= RST_WINDOW;
    end else if (wr_fire) begin
      if (wr_idx == IDX_MAIN)   main_q   <= wr_byte & MASK_MAIN;
      if (wr_idx == IDX_ACCUM)  accum_q  <= wr_byte & MASK_ACCUM;
      if (wr_idx == IDX_REFCLK) refclk_q <= wr_byte & MASK_REFCLK;
      if (wr_idx == IDX_WINDOW) window_q <= wr_byte & MASK_WINDOW;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timing_q <= RST_TIMING;
    end else if (wr_fire && wr_idx == IDX_TIMING) begin
      timing_q <= wr_byte & MASK_TIMING;
    end else if (sample_end && timing_q[BIT_VARIATE]) begin
      timing_q[3:0] <= timing_q[3:0] + 4'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      start_q <= 1'b0;
    end else if (wr_fire && wr_idx == IDX_COMMAND && wr_byte[BIT_START] && main_q[BIT_ENABLE] &&
                 refclk_q[5:4] != REF_RESERVED) begin
      start_q <= 1'b1;
    end else if (!main_q[BIT_ENABLE] || (done_pulse && !main_q[BIT_CONTINUOUS_CONVERSION])) begin
      start_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      result_ready_flag_q <= 1'b0;
    end else if (done_pulse) begin
      result_ready_flag_q <= 1'b1;
    end else if (wr_fire && wr_idx == IDX_FLAGS && wr_byte[BIT_RESULT_READY_FLAG]) begin
      result_ready_flag_q <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // converter clock
  // -------------------------------------------------------------------------
  // divide by 2 shl code
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_cnt_q <= 8'h00;
      cclk_q    <= 1'b0;
      ctick_q   <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_q + 8'h01;
      ctick_q   <= 1'b0;
      if ((div_cnt_q & ((8'h01 << refclk_q[2:0]) - 8'h01)) == ((8'h01 << refclk_q[2:0]) - 8'h01)) begin
        cclk_q <= !cclk_q;
        ctick_q <= cclk_q;
      end
    end
  end
  assign converter_clock = cclk_q;

  // -------------------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------------------
  // halts in standby unless allowed
  assign running = main_q[BIT_ENABLE] && (!standby_sleep || main_q[BIT_STBYRUN]);
  assign samples_total = (accum_q[2:0] == ACC_RESERVED) ? 7'd1 : 7'(7'd1 << accum_q[2:0]);
  assign startup_cycles = (timing_q[7:5] == 3'h0 || timing_q[7:5] > STARTUP_MAX) ? 9'd0
                        : 9'(STARTUP_BASE << (timing_q[7:5] - 3'h1));
  assign startup_trig = (main_q[BIT_ENABLE] && !enable_prev_q) ||
                        (refclk_q[5:4] == REF_INTERNAL && !refint_prev_q) || deep_sleep_wake;
  assign trimmed = main_q[BIT_RES8] ? {2'b00, sample_value[9:2]} : sample_value;
  // a stalled sequencer must not step the delay or repeat the completion pulse
  assign sample_end = running && (state_q == ST_CONVERT) && ctick_q && wait_q == 9'd0;
  assign done_pulse = running && (state_q == ST_DONE);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      enable_prev_q <= 1'b0;
      refint_prev_q <= 1'b1;
    end else begin
      enable_prev_q <= main_q[BIT_ENABLE];
      refint_prev_q <= (refclk_q[5:4] == REF_INTERNAL);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q   <= ST_IDLE;
      wait_q    <= 9'd0;
      samples_q <= 7'd0;
      acc_sum_q <= 16'h0000;
      result_q  <= 16'h0000;
    end else if (!main_q[BIT_ENABLE]) begin
      state_q <= ST_IDLE;
    end else if (startup_trig && state_q == ST_IDLE) begin
      state_q <= ST_STARTUP;
      wait_q  <= startup_cycles;
    end else if (running) begin
      case (state_q)
        ST_IDLE: begin
          if (start_q && refclk_q[5:4] != REF_RESERVED) begin
            state_q   <= ST_CONVERT;
            wait_q    <= 9'(CONV_CYCLES);
            samples_q <= 7'd0;
            acc_sum_q <= 16'h0000;
          end
        end
        ST_STARTUP: begin
          if (wait_q == 9'd0) state_q <= ST_IDLE;
          else if (ctick_q) wait_q <= wait_q - 9'd1;
        end
        ST_CONVERT: begin
          if (ctick_q && wait_q != 9'd0) begin
            wait_q <= wait_q - 9'd1;
          end else if (sample_end) begin
            acc_sum_q <= acc_sum_q + {6'h00, trimmed};
            samples_q <= samples_q + 7'd1;
            if (samples_q + 7'd1 >= samples_total) begin
              state_q <= ST_DONE;
            end else begin
              state_q <= ST_GAP;
              wait_q  <= {5'h00, timing_q[3:0]};
            end
          end
        end
        ST_GAP: begin
          if (wait_q == 9'd0) begin
            state_q <= ST_CONVERT;
            wait_q  <= 9'(CONV_CYCLES);
          end else if (ctick_q) begin
            wait_q <= wait_q - 9'd1;
          end
        end
        ST_DONE: begin
          result_q <= acc_sum_q;
          if (main_q[BIT_CONTINUOUS_CONVERSION] && start_q) begin
            state_q   <= ST_CONVERT;
            wait_q    <= 9'(CONV_CYCLES);
            samples_q <= 7'd0;
            acc_sum_q <= 16'h0000;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // front-end outputs
  // -------------------------------------------------------------------------
  // cap open in gap
  assign sample_cap_closed  = (state_q == ST_CONVERT);
  assign sample_cap_reduced = refclk_q[BIT_SAMPLE_CAP_SELECT];
  assign reference_sel_out  = refclk_q[5:4];
  assign window_mode_out    = (window_q[2:0] > WIN_MAX) ? 3'h0 : window_q[2:0];
  assign result_ready_event = done_pulse;

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  gap_cap_open_a: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == ST_GAP |-> !sample_cap_closed) else $error("cap closed during gap");
  flag_sets_a: assert property (@(posedge clk_sys) disable iff (rst)
    done_pulse |=> result_ready_flag_q) else $error("result flag not set");
  start_clears_a: assert property (@(posedge clk_sys) disable iff (rst)
    done_pulse && !main_q[BIT_CONTINUOUS_CONVERSION] && !(wr_fire && wr_idx == IDX_COMMAND) |=> !start_q)
    else $error("start did not clear");
  disable_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
    !main_q[BIT_ENABLE] |=> state_q == ST_IDLE) else $error("runs while disabled");
  resolution_trim_a: assert property (@(posedge clk_sys) disable iff (rst)
    main_q[BIT_RES8] |-> trimmed[9:8] == 2'b00) else $error("low bits kept");
  variation_wrap_a: assert property (@(posedge clk_sys) disable iff (rst)
    sample_end && timing_q[BIT_VARIATE] && !(wr_fire && wr_idx == IDX_TIMING)
    |=> timing_q[3:0] == $past(timing_q[3:0]) + 4'h1) else $error("delay not stepped");
  reserved_count_a: assert property (@(posedge clk_sys) disable iff (rst)
    accum_q[2:0] == ACC_RESERVED |-> samples_total == 7'd1) else $error("reserved count used");
  continuous_conversion_restart_a: assert property (@(posedge clk_sys) disable iff (rst)
    done_pulse && running && main_q[BIT_CONTINUOUS_CONVERSION] && start_q && !startup_trig
    |=> state_q == ST_CONVERT) else $error("no restart");

endmodule // adc_conversion_control

// ===== tb/afe_model.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// analog front end
// ---------------------------------------------------------------
module afe_model (
  // sampling control
  input  wire logic       cap_closed,
  input  wire logic [9:0] level,
  // conversion input
  output      logic [9:0] sample_value
);
  // an open cap leaves the line floating: show the inverse
  assign sample_value = cap_closed ? level : ~level;
endmodule // afe_model

// ===== tb/tb.sv
`timescale 1ns/1ns
module tb;
  import adc_ctrl_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk_sys, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, standby_sleep, deep_sleep_wake, converter_clock;
  logic        sample_cap_closed, sample_cap_reduced, result_ready_event;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp_q, reference_sel_out;
  logic [9:0]  sample_value, level;
  logic [2:0]  window_mode_out;
  int          miscompares = 0, check_count = 0, evt_cnt = 0, e0, g0, open_cnt = 0, gap_len = 0;
  time         t0;
  typedef struct packed {
    logic [7:0]  main;
    logic [7:0]  acc;
    logic [9:0]  lvl;
    logic [15:0] res;
  } row_t;
  row_t rows [10] = '{'{8'h01, 8'h00, 10'h2A5, 16'h02A5}, '{8'h05, 8'h00, 10'h2A5, 16'h00A9},
    '{8'h01, 8'h01, 10'h2A5, 16'h054A}, '{8'h01, 8'h02, 10'h3FF, 16'h0FFC},
    '{8'h01, 8'h03, 10'h3FF, 16'h1FF8}, '{8'h01, 8'h04, 10'h3FF, 16'h3FF0},
    '{8'h01, 8'h05, 10'h3FF, 16'h7FE0}, '{8'h01, 8'h06, 10'h3FF, 16'hFFC0},
    '{8'h05, 8'h06, 10'h3FF, 16'h3FC0}, '{8'h01, 8'h07, 10'h123, 16'h0123}};
  logic [7:0]  mask [5] = '{8'h87, 8'h07, 8'h77, 8'hFF, 8'h07};

  // ---------------------------------------------------------------
  // design and front end
  // ---------------------------------------------------------------
  adc_conversion_control u_adc_conversion_control (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .standby_sleep, .deep_sleep_wake, .sample_value,
    .converter_clock, .sample_cap_closed, .sample_cap_reduced, .reference_sel_out, .window_mode_out,
    .result_ready_event);
  afe_model u_afe_model (.cap_closed(sample_cap_closed), .level(level), .sample_value(sample_value));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (result_ready_event === 1'b1) evt_cnt <= evt_cnt + 1;
  // length of the last open-cap run that ended in a close
  always @(posedge clk_sys) begin
    if (sample_cap_closed === 1'b1) begin
      if (open_cnt > 0) gap_len <= open_cnt;
      open_cnt <= 0;
    end else begin
      open_cnt <= open_cnt + 1;
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= {idx[5:0], 2'b00};
    s_axi_wdata <= {24'h000000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    resp_q = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] idx);
    @(posedge clk_sys);
    s_axi_araddr <= {idx[5:0], 2'b00};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd_q = s_axi_rdata;
    resp_q = s_axi_rresp;
  endtask
  // start a conversion and note the event count first
  task automatic go();
    e0 = evt_cnt;
    wr(IDX_COMMAND, 8'h01);
  endtask
  task automatic wait_evt(input int k);
    int n = 0;
    while (evt_cnt < e0 + k && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    chk(evt_cnt - e0, k);
  endtask
  task automatic wrap_up();
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #900_000;
    miscompares++;
    wrap_up();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
    s_axi_wstrb <= 4'h1;
    {standby_sleep, deep_sleep_wake, rst} <= 3'h1;
    level <= 10'h000;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wr(IDX_MAIN, rows[i].main);
      chk(resp_q, AXI_OKAY);
      wr(IDX_ACCUM, rows[i].acc);
      level <= rows[i].lvl;
      go();
      rd(IDX_COMMAND);
      chk(rd_q, 32'h1);
      wait_evt(1);
      repeat (40) @(posedge clk_sys);
      chk(evt_cnt - e0, 1);
      rd(IDX_RESULT);
      chk(rd_q, {16'h0000, rows[i].res});
      rd(IDX_COMMAND);
      chk(rd_q, 32'h0);
      rd(IDX_FLAGS);
      chk(rd_q, 32'h1);
      wr(IDX_FLAGS, 8'h01);
      rd(IDX_FLAGS);
      chk(rd_q, 32'h0);
    end
    // delay variation wraps after one sample
    wr(IDX_ACCUM, 8'h00);
    wr(IDX_TIMING, 8'h1F);
    go();
    wait_evt(1);
    rd(IDX_TIMING);
    chk(rd_q, 32'h10);
    // two samples: gap of 4 converter clocks against a gap of none
    wr(IDX_ACCUM, 8'h01);
    wr(IDX_TIMING, 8'h04);
    go();
    wait_evt(1);
    g0 = gap_len;
    wr(IDX_TIMING, 8'h00);
    go();
    wait_evt(1);
    chk(g0 - gap_len, 8);
    // wake from deep sleep waits 16 converter clocks before sampling
    wr(IDX_TIMING, 8'h20);
    deep_sleep_wake <= 1'b1;
    @(posedge clk_sys);
    deep_sleep_wake <= 1'b0;
    go();
    repeat (20) @(posedge clk_sys);
    chk(sample_cap_closed, 1'b0);
    wait_evt(1);
    wr(IDX_TIMING, 8'h00);
    wr(IDX_ACCUM, 8'h00);
    // converter clock divider
    for (int c = 0; c < 8; c += 3) begin
      wr(IDX_REFCLK, c[7:0]);
      repeat (3) @(posedge converter_clock);
      t0 = $time;
      @(posedge converter_clock);
      chk(32'(($time - t0) / 10), 32'(2 << c));
    end
    // free running until disabled
    wr(IDX_REFCLK, 8'h00);
    wr(IDX_MAIN, 8'h03);
    go();
    wait_evt(3);
    rd(IDX_FLAGS);
    chk(rd_q, 32'h1);
    rd(IDX_COMMAND);
    chk(rd_q, 32'h1);
    wr(IDX_MAIN, 8'h00);
    repeat (60) @(posedge clk_sys);
    e0 = evt_cnt;
    repeat (200) @(posedge clk_sys);
    chk(evt_cnt - e0, 0);
    go();
    rd(IDX_COMMAND);
    chk(rd_q, 32'h0);
    // reserved reference starts nothing
    wr(IDX_MAIN, 8'h01);
    wr(IDX_REFCLK, 8'h30);
    go();
    rd(IDX_COMMAND);
    chk(rd_q, 32'h0);
    repeat (100) @(posedge clk_sys);
    chk(evt_cnt - e0, 0);
    for (int r = 0; r < 4; r++) begin
      wr(IDX_REFCLK, {2'b01, r[1:0], 4'h0});
      chk(reference_sel_out, r[1:0]);
      chk(sample_cap_reduced, 1'b1);
    end
    for (int w = 0; w < 8; w++) begin
      wr(IDX_WINDOW, w[7:0]);
      chk(window_mode_out, (w <= 4) ? w[2:0] : 3'h0);
    end
    // standby: runs only when allowed
    wr(IDX_REFCLK, 8'h00);
    wr(IDX_MAIN, 8'h81);
    standby_sleep <= 1'b1;
    go();
    wait_evt(1);
    wr(IDX_MAIN, 8'h01);
    go();
    repeat (200) @(posedge clk_sys);
    chk(evt_cnt - e0, 0);
    standby_sleep <= 1'b0;
    wait_evt(1);
    // writable bits, then reset with the converter enabled but idle
    for (int i = 0; i < 5; i++) begin
      wr(i[7:0], 8'hFF);
      rd(i[7:0]);
      chk(rd_q, {24'h0, mask[i]});
    end
    rst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(i[7:0]);
      chk(rd_q, 32'h0);
    end
    rd(8'h3F);
    chk(rd_q, 32'h0);
    chk(resp_q, AXI_SLVERR);
    wrap_up();
  end
endmodule // tb
